// ---- design/card_regs_pkg.sv ----
// Constants, field layouts and types shared by the card information registers
package card_regs_pkg;

  localparam int OCR_W = 32;
  localparam int CID_W = 128;
  localparam int CSD_W = 128;
  localparam int VDD_W = 9;
  localparam int OCR_VDD_LO = 15;
  localparam int OCR_VDD_HI = 23;
  localparam int OCR_DUALV_BIT = 7;
  localparam int OCR_CCS_BIT = 30;
  localparam int OCR_BUSY_BIT = 31;

  localparam int CRC_W = 7;
  localparam logic [CRC_W-1:0] CRC_POLY = 7'h09;
  localparam logic [CRC_W-1:0] CRC_INIT = 7'h00;
  localparam logic [6:0] CRC_IDX_FIRST = 7'h7F;
  localparam logic [6:0] CRC_IDX_LAST = 7'h08;

  localparam int CSD_STRUCT_HI = 127;
  localparam int CSD_STRUCT_LO = 126;
  localparam logic [1:0] CSD_VER1 = 2'h0;
  localparam logic [1:0] CSD_VER2 = 2'h1;
  localparam int CSD_COPY_BIT = 14;
  localparam int CSD_PERM_BIT = 13;
  localparam int CSD_TMP_BIT = 12;

  localparam int CLK_PERIOD_NS = 40;
  localparam int PWRUP_TIME_NS = 10000;
  localparam int PWRUP_CYC = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) /
                             CLK_PERIOD_NS;
  localparam int PWR_CNT_W = $clog2(PWRUP_CYC + 1);
  localparam logic [PWR_CNT_W-1:0] PWR_CNT_END = PWR_CNT_W'(PWRUP_CYC - 1);
  localparam logic [PWR_CNT_W-1:0] PWR_CNT_RST = '0;

  typedef enum logic [1:0] {
    SEL_OCR = 2'b00,
    SEL_CID = 2'b01,
    SEL_CSD = 2'b10
  } reg_sel_t;

  typedef enum logic [1:0] {
    PWR_CRC = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_READY = 2'b10
  } pwr_state_t;

  // Identity body, bits 127 down to 8 of the identity word
  typedef struct packed {
    logic [7:0] maker_code;
    logic [15:0] integrator_code;
    logic [39:0] product_name_field;
    logic [7:0] product_revision_field;
    logic [31:0] serial_number_field;
    logic [3:0] reserved;
    logic [7:0] year_code;
    logic [3:0] month_code;
  } id_fields_t;

  typedef struct packed {
    logic copy;
    logic perm_wp;
    logic tmp_wp;
  } csd_wp_t;

  // Arbitrary neutral identity values
  localparam id_fields_t ID_DEFAULT = '{
    maker_code: 8'h5A,
    integrator_code: 16'h5859,
    product_name_field: 40'h4142434445,
    product_revision_field: 8'h10,
    serial_number_field: 32'h00000001,
    reserved: 4'h0,
    year_code: 8'h01,
    month_code: 4'h4
  };

endpackage

// ---- design/card_condition_identity_regs.sv ----
// Operation-conditions, identity and card-specific-data information registers
// What this block does
// R1 - Bits 15..23 of the conditions word flag supported 0.1 V windows.
// R2 - Bit 31 stays low during power-up, high once it finished.
// R3 - Bit 30 reads 1 for high-capacity, 0 for standard-capacity cards.
// R4 - Capacity flag is only meaningful once power-up bit reads high.
// R5 - Host reads capacity flag after power-up to learn the card class.
// R6 - Bit 7 resets to 0, set once a dual-voltage card sees CMD8.
// R7 - A 128-bit identity word, unique for each card.
// R8 - Bits 127:120 hold the 8-bit maker code.
// R9 - Bits 119:104 hold the two-character integrator code.
// R10 - Bits 103:64 hold the five-character product name.
// R11 - Bits 63:56 hold revision n.m as two BCD nibbles.
// R12 - Bits 55:24 hold the serial number; bits 23:20 reserved.
// R13 - Year code in bits 19:12 from 2000, month in 11:8.
// R14 - CRC7 in bits 7:1, bit 0 always reads 1.
// R15 - Data layout version 2.0 only for high-capacity cards.
// R16 - Read-only, write-once and rewritable fields by cell type.
// R17 - Registers reached only through card commands, not memory-mapped.
// R18 - CRC7 polynomial x^7+x^3+1 over bits 127..8, MSB first.
`timescale 1ns/1ns
`default_nettype none

module card_condition_identity_regs
  import card_regs_pkg::*;
#(
  parameter logic [VDD_W-1:0] VDD_WINDOW = 9'h1FF,
  parameter id_fields_t ID_FIELDS = ID_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cap_strap,
  input wire logic dual_strap,
  input wire logic cmd8_rcvd,
  input wire logic rd_req,
  input wire reg_sel_t rd_sel,
  input wire logic csd_wr,
  input wire csd_wp_t csd_wr_data,
  output logic rd_ack,
  output logic [CID_W-1:0] rd_data,
  output logic power_ready
);

  pwr_state_t pwr_state_ff;
  pwr_state_t nxt_pwr_state;
  logic [PWR_CNT_W-1:0] pwr_cnt_ff;
  logic [PWR_CNT_W-1:0] nxt_pwr_cnt;
  logic [6:0] crc_idx_ff;
  logic [6:0] nxt_crc_idx;
  logic [CRC_W-1:0] crc_ff;
  logic [CRC_W-1:0] nxt_crc;
  logic cap_ff;
  logic dualv_ff;
  csd_wp_t wp_ff;
  csd_wp_t nxt_wp;
  logic otp_lock_ff;
  logic rd_ack_ff;
  logic [CID_W-1:0] rd_data_ff;
  logic [CID_W-1:0] nxt_rd_data;

  logic [CID_W-CRC_W-2:0] id_body;
  logic [6:0] body_pos;
  logic crc_in_bit;
  logic crc_fb;
  logic crc_running;
  logic crc_last;
  logic cnt_done;
  logic ready;
  logic [OCR_W-1:0] ocr_word;
  logic [CID_W-1:0] cid_word;
  logic [CSD_W-1:0] csd_word;
  logic [1:0] csd_struct;

  // Power-up sequencing: checksum first, then the remaining settle time
  assign crc_running = (pwr_state_ff == PWR_CRC);
  assign crc_last = crc_running && (crc_idx_ff == CRC_IDX_LAST);
  assign cnt_done = (pwr_cnt_ff == PWR_CNT_END);
  assign ready = (pwr_state_ff == PWR_READY);
  assign power_ready = ready;
  assign nxt_pwr_cnt = cnt_done ? pwr_cnt_ff :
                       pwr_cnt_ff + PWR_CNT_W'(1);

  always_comb begin
    case (pwr_state_ff)
      PWR_CRC: nxt_pwr_state = crc_last ? PWR_WAIT : PWR_CRC;
      PWR_WAIT: nxt_pwr_state = cnt_done ? PWR_READY : PWR_WAIT;
      PWR_READY: nxt_pwr_state = PWR_READY;
      default: nxt_pwr_state = PWR_CRC;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_state_ff <= PWR_CRC;
      pwr_cnt_ff <= PWR_CNT_RST;
    end else begin
      pwr_state_ff <= nxt_pwr_state; // R2
      pwr_cnt_ff <= nxt_pwr_cnt;
    end
  end

  // Serial checksum over the identity body, one bit per clock
  assign id_body = ID_FIELDS;
  assign body_pos = crc_idx_ff - CRC_IDX_LAST;
  assign crc_in_bit = id_body[body_pos];
  assign crc_fb = crc_in_bit ^ crc_ff[CRC_W-1]; // R18
  assign nxt_crc = !crc_running ? crc_ff :
                   ({crc_ff[CRC_W-2:0], 1'b0} ^
                    (crc_fb ? CRC_POLY : CRC_INIT)); // R18
  assign nxt_crc_idx = crc_running ? crc_idx_ff - 7'h01 : crc_idx_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_ff <= CRC_INIT;
      crc_idx_ff <= CRC_IDX_FIRST;
    end else begin
      crc_ff <= nxt_crc;
      crc_idx_ff <= nxt_crc_idx;
    end
  end

  // Capacity strap caught as power-up ends; flag means nothing before
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cap_ff <= 1'b0;
    end else if (pwr_state_ff == PWR_WAIT && cnt_done) begin
      cap_ff <= cap_strap; // R3 R4
    end
  end

  // Once set by CMD8 the dual-voltage bit holds until reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dualv_ff <= 1'b0; // R6
    end else begin
      dualv_ff <= dualv_ff | (cmd8_rcvd & dual_strap); // R6
    end
  end

  // Conditions word, one bit per position
  genvar gi;
  generate
    for (gi = 0; gi < OCR_W; gi++) begin : g_ocr
      if (gi >= OCR_VDD_LO && gi <= OCR_VDD_HI) begin : g_vdd
        assign ocr_word[gi] = VDD_WINDOW[gi-OCR_VDD_LO]; // R1
      end else if (gi == OCR_BUSY_BIT) begin : g_busy
        assign ocr_word[gi] = ready; // R2
      end else if (gi == OCR_CCS_BIT) begin : g_ccs
        assign ocr_word[gi] = cap_ff; // R3
      end else if (gi == OCR_DUALV_BIT) begin : g_dualv
        assign ocr_word[gi] = dualv_ff; // R6
      end else begin : g_rsvd
        assign ocr_word[gi] = 1'b0;
      end
    end
  endgenerate

  // Identity word: fixed body, computed checksum, stop bit
  assign cid_word = {ID_FIELDS, crc_ff, 1'b1}; // R7 R8 R9 R10 R11 R12 R13 R14

  // Copy and permanent protect are one-time; temporary stays rewritable
  assign nxt_wp.tmp_wp = csd_wr ? csd_wr_data.tmp_wp : wp_ff.tmp_wp; // R16
  assign nxt_wp.copy = (csd_wr && !otp_lock_ff) ? csd_wr_data.copy :
                       wp_ff.copy; // R16
  assign nxt_wp.perm_wp = (csd_wr && !otp_lock_ff) ? csd_wr_data.perm_wp :
                          wp_ff.perm_wp; // R16

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_ff <= '0;
      otp_lock_ff <= 1'b0;
    end else begin
      wp_ff <= nxt_wp;
      otp_lock_ff <= otp_lock_ff | csd_wr; // R16
    end
  end

  // Only the layout version, protection cells and a fixed 1 in bit 0 live here
  assign csd_struct = cap_ff ? CSD_VER2 : CSD_VER1; // R15
  generate
    for (gi = 0; gi < CSD_W; gi++) begin : g_csd
      if (gi == CSD_STRUCT_HI || gi == CSD_STRUCT_LO) begin : g_st
        assign csd_word[gi] = csd_struct[gi-CSD_STRUCT_LO]; // R15
      end else if (gi == CSD_COPY_BIT) begin : g_cp
        assign csd_word[gi] = wp_ff.copy;
      end else if (gi == CSD_PERM_BIT) begin : g_pw
        assign csd_word[gi] = wp_ff.perm_wp;
      end else if (gi == CSD_TMP_BIT) begin : g_tw
        assign csd_word[gi] = wp_ff.tmp_wp;
      end else if (gi == 0) begin : g_one
        assign csd_word[gi] = 1'b1;
      end else begin : g_fix
        assign csd_word[gi] = 1'b0;
      end
    end
  endgenerate

  // Command-side read port; unused select answers with zeros
  assign nxt_rd_data = !rd_req ? rd_data_ff :
                       (rd_sel == SEL_OCR) ? {{(CID_W-OCR_W){1'b0}}, ocr_word} :
                       (rd_sel == SEL_CID) ? cid_word :
                       (rd_sel == SEL_CSD) ? csd_word :
                       '0; // R17

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_ack_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_ack_ff <= rd_req; // R17
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_ack = rd_ack_ff;
  assign rd_data = rd_data_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ocr_req;
    rd_req && rd_sel == SEL_OCR;
  endsequence

  sequence s_ocr_ans;
    rd_ack && rd_data[OCR_W-1:0] == $past(ocr_word);
  endsequence

  busy_while_pwrup_a: assert property ( // R2
    !ready |-> !ocr_word[OCR_BUSY_BIT])
    else $error("busy bit high before power-up done");

  ready_stays_a: assert property ( // R2
    ready |=> ready && ocr_word[OCR_BUSY_BIT])
    else $error("power-up bit fell after completion");

  cap_gated_a: assert property ( // R4
    !ocr_word[OCR_BUSY_BIT] |-> !ocr_word[OCR_CCS_BIT])
    else $error("capacity flag set before power-up");

  cap_capture_a: assert property ( // R3
    (pwr_state_ff == PWR_WAIT && cnt_done) |=>
      ocr_word[OCR_CCS_BIT] == $past(cap_strap))
    else $error("capacity flag not taken from strap");

  dualv_set_a: assert property ( // R6
    cmd8_rcvd && dual_strap |=> ocr_word[OCR_DUALV_BIT] [*3])
    else $error("dual-voltage bit not set after CMD8");

  dualv_cause_a: assert property ( // R6
    $rose(ocr_word[OCR_DUALV_BIT]) |-> $past(cmd8_rcvd && dual_strap))
    else $error("dual-voltage bit rose without CMD8");

  window_bits_a: assert property ( // R1
    ocr_word[OCR_VDD_HI:OCR_VDD_LO] == VDD_WINDOW &&
    ocr_word[OCR_VDD_LO-1:OCR_DUALV_BIT+1] == '0)
    else $error("voltage window bits wrong");

  cid_stop_a: assert property ( // R14
    rd_req && rd_sel == SEL_CID |=> rd_data[0] &&
      rd_data[CID_W-1:CRC_W+1] == ID_FIELDS)
    else $error("identity word body or stop bit wrong");

  crc_time_a: assert property ( // R18
    $fell(crc_running) |-> $past(crc_idx_ff) == CRC_IDX_LAST)
    else $error("checksum ended at wrong bit");

  ocr_read_a: assert property ( // R17
    s_ocr_req |=> s_ocr_ans ##1 (rd_ack == $past(rd_req)))
    else $error("conditions read answer wrong");

  otp_hold_a: assert property ( // R16
    otp_lock_ff && csd_wr |=> $stable(wp_ff.copy) && $stable(wp_ff.perm_wp))
    else $error("one-time cell rewritten");

  csd_version_a: assert property ( // R15
    csd_word[CSD_STRUCT_HI:CSD_STRUCT_LO] == (cap_ff ? CSD_VER2 : CSD_VER1))
    else $error("layout version does not follow capacity");

  ack_pulse_a: assert property ( // R17
    rd_req |=> rd_ack)
    else $error("read request not answered");

  unmapped_zero_a: assert property ( // R17
    rd_req && !(rd_sel inside {SEL_OCR, SEL_CID, SEL_CSD}) |=> rd_data == '0)
    else $error("unmapped select did not answer zeros");

  tmp_write_a: assert property ( // R16
    csd_wr |=> wp_ff.tmp_wp == $past(csd_wr_data.tmp_wp))
    else $error("rewritable cell not written");

  first_write_a: assert property ( // R16
    csd_wr && !otp_lock_ff |=> otp_lock_ff &&
      wp_ff.copy == $past(csd_wr_data.copy))
    else $error("first write to one-time cell lost");

  rsvd_zero_a: assert property ( // R1
    ocr_word[OCR_CCS_BIT-1:OCR_VDD_HI+1] == '0 &&
    ocr_word[OCR_DUALV_BIT-1:0] == '0)
    else $error("reserved conditions bits not zero");

  ready_after_crc_a: assert property ( // R2 R18
    ready |-> !crc_running)
    else $error("power-up done while checksum still running");

endmodule

`default_nettype wire

// ---- test/card_host_model.sv ----
// Host-side command model that issues register reads to the card
`timescale 1ns/1ns
`default_nettype none

module card_host_model
  import card_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rd_ack,
  input wire logic [CID_W-1:0] rd_data,
  output var logic rd_req,
  output var reg_sel_t rd_sel
);
  initial begin
    rd_req = 1'b0;
    rd_sel = SEL_OCR;
  end

  // Words are fetched by command only, never by address
  task automatic read_word(input reg_sel_t sel, output logic ack,
                           output logic [CID_W-1:0] data);
    @(posedge mclk);
    rd_req <= 1'b1;
    rd_sel <= sel;
    @(posedge mclk);
    rd_req <= 1'b0;
    // Idle select shows junk so the design cannot lean on a stale value
    rd_sel <= reg_sel_t'(~sel);
    @(negedge mclk);
    ack = rd_ack;
    data = rd_data;
  endtask
endmodule

`default_nettype wire

// ---- test/test_card_condition_identity_regs.sv ----
// Self-checking bench for the card information registers
`timescale 1ns/1ns
`default_nettype none

module test_card_condition_identity_regs import card_regs_pkg::*;;
  localparam logic [VDD_W-1:0] WIN = 9'h0A5;
  logic mclk, rst, cap_strap, dual_strap, cmd8_rcvd, csd_wr;
  logic rd_req, rd_ack, power_ready, ack;
  reg_sel_t rd_sel;
  csd_wp_t csd_wr_data;
  logic [CID_W-1:0] rd_data, word, card_identity_word;
  logic [31:0] operating_conditions_word;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int rel_cyc = 0;

  card_condition_identity_regs #(.VDD_WINDOW(WIN), .ID_FIELDS(ID_DEFAULT))
    i_card_condition_identity_regs (
    .mclk(mclk), .rst(rst), .cap_strap(cap_strap),
    .dual_strap(dual_strap), .cmd8_rcvd(cmd8_rcvd), .rd_req(rd_req),
    .rd_sel(rd_sel), .csd_wr(csd_wr), .csd_wr_data(csd_wr_data),
    .rd_ack(rd_ack), .rd_data(rd_data), .power_ready(power_ready));

  card_host_model i_card_host_model (
    .mclk(mclk), .rd_ack(rd_ack), .rd_data(rd_data), .rd_req(rd_req),
    .rd_sel(rd_sel));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
             fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Run is about 600 cycles; the 2000-cycle watchdog lies well above this
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    rel_cyc <= rst ? 0 : rel_cyc + 1;
    if (cycles == 2000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end

  task automatic check_word(input logic [CID_W-1:0] got, exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, exp);
    check_word(CID_W'(got), CID_W'(exp));
  endtask

  function automatic logic [6:0] crc7(input logic [119:0] body);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = body[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [CID_W-1:0] card_specific_data_word(input logic [1:0] ver,
                                           input logic [2:0] cells);
    card_specific_data_word = '0;
    card_specific_data_word[127:126] = ver;
    card_specific_data_word[14:12] = cells;
    card_specific_data_word[0] = 1'b1;
  endfunction

  task automatic rd(input reg_sel_t sel, input logic [CID_W-1:0] exp);
    i_card_host_model.read_word(sel, ack, word);
    check_bit(ack, 1'b1);
    check_word(word, exp);
  endtask

  task automatic cmd8;
    @(posedge mclk);
    cmd8_rcvd <= 1'b1;
    @(posedge mclk);
    cmd8_rcvd <= 1'b0;
  endtask

  task automatic wr_cells(input csd_wp_t d);
    @(posedge mclk);
    csd_wr <= 1'b1;
    csd_wr_data <= d;
    @(posedge mclk);
    csd_wr <= 1'b0;
    csd_wr_data <= ~d;
  endtask

  task automatic do_reset(input logic cap, dual);
    @(posedge mclk);
    rst <= 1'b1;
    cap_strap <= cap;
    dual_strap <= dual;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    cap_strap = 1'b0;
    dual_strap = 1'b0;
    cmd8_rcvd = 1'b0;
    csd_wr = 1'b0;
    csd_wr_data = '0;
    operating_conditions_word = 32'(WIN) << OCR_VDD_LO;
    card_identity_word = {ID_DEFAULT, crc7(ID_DEFAULT), 1'b1};
    do_reset(1'b1, 1'b1);
    rd(SEL_OCR, CID_W'(operating_conditions_word));
    while (rel_cyc != 249) @(negedge mclk);
    check_bit(power_ready, 1'b0);
    @(negedge mclk);
    check_bit(power_ready, 1'b1);
    rd(SEL_OCR, CID_W'(operating_conditions_word | 32'hC0000000));
    cmd8;
    rd(SEL_OCR, CID_W'(operating_conditions_word | 32'hC0000080));
    rd(SEL_CID, card_identity_word);
    rd(reg_sel_t'(2'b11), '0);
    wr_cells(3'b111);
    rd(SEL_CSD, card_specific_data_word(2'b01, 3'b111));
    wr_cells(3'b000);
    rd(SEL_CSD, card_specific_data_word(2'b01, 3'b110));
    // Standard card without dual-voltage support ignores the command
    do_reset(1'b0, 1'b0);
    cmd8;
    while (rel_cyc != 250) @(negedge mclk);
    rd(SEL_OCR, CID_W'(operating_conditions_word | 32'h80000000));
    rd(SEL_CSD, card_specific_data_word(2'b00, 3'b000));
    wr_cells(3'b010);
    wr_cells(3'b101);
    rd(SEL_CSD, card_specific_data_word(2'b00, 3'b011));
    print_verdict;
  end
endmodule

`default_nettype wire
